// ==== rtl/efs_pkg.sv ====
// Contract
// RL1 - flag register change while check enabled
// RL2 - host keeps check off during config writes
// RL3 - checksum registers, flag mismatch against snapshot
// RL4 - only clearing check enable clears flag
// RL5 - skip data, status, interface mode registers
// RL6 - pin role needs sync enable, no alternate
// RL7 - function 10: open-drain inverted fault OR
// RL8 - host reads status after pin fault
// RL9 - function 01: inverted pin joins conversion fault
// RL10 - input mode copies pin into status
// RL11 - function 00 off, 11 general output
// RL12 - append status after every conversion result
// RL13 - status low bits carry channel number
// RL14 - general output drives configured pin level
// RL15 - checksum fault set, cleared by status read
// RL16 - conversion fault follows range condition, not latched
// RL17 - flags readable in status any time
package efs_pkg;

	// register offsets
	localparam logic [7:0] EFS_OFS_STATUS   = 8'h00;
	localparam logic [7:0] EFS_OFS_IFMODE   = 8'h02;
	localparam logic [7:0] EFS_OFS_REGCHECK = 8'h03;
	localparam logic [7:0] EFS_OFS_DATA     = 8'h04;
	localparam logic [7:0] EFS_OFS_PINCFG   = 8'h06;
	localparam logic [7:0] EFS_OFS_CFG0     = 8'h10;
	localparam logic [7:0] EFS_OFS_IRQ_ST   = 8'h30;
	localparam logic [7:0] EFS_OFS_IRQ_MASK = 8'h31;

	// field positions
	localparam int EFS_IF_ALT_START  = 12;
	localparam int EFS_IF_APPEND     = 6;
	localparam int EFS_IF_CHECK_EN   = 5;
	localparam int EFS_PC_SYNC_EN    = 11;
	localparam int EFS_PC_FN_LO      = 9;
	localparam int EFS_PC_PIN_LEVEL  = 8;
	localparam int EFS_CFG_COUNT     = 4;
	localparam int EFS_MON_WORDS     = 5;

	// reset values
	localparam logic [15:0] EFS_RST_IFMODE = 16'h0000;
	localparam logic [15:0] EFS_RST_PINCFG = 16'h0800;
	localparam logic [15:0] EFS_RST_CFG0   = 16'h8001;
	localparam logic [15:0] EFS_RST_CFGN   = 16'h0001;
	localparam logic [23:0] EFS_RST_CHKSUM = 24'h000000;

	// pin function codes
	typedef enum logic [1:0] {
		EFS_FN_OFF   = 2'b00,
		EFS_FN_IN    = 2'b01,
		EFS_FN_OD    = 2'b10,
		EFS_FN_GPOUT = 2'b11
	} efs_pinfn_t;

	// conversion arriving from the filter
	typedef struct packed {
		logic [23:0] data;
		logic [1:0]  chan;
	} efs_conv_t;

	// result leaving towards the serial interface
	typedef struct packed {
		logic [23:0] data;
		logic [7:0]  stat;
		logic        with_stat;
	} efs_result_t;

endpackage

// ==== rtl/efs_regchk.sv ====
`timescale 1ns/1ns
// register integrity checker: snapshot on enable, compare every cycle
module efs_regchk
	import efs_pkg::*;
(
	// clock and reset
	input  wire logic                          sys_clk,
	input  wire logic                          rstn,
	// control
	input  wire logic                          chk_en,
	input  wire logic [EFS_MON_WORDS*16-1:0]   mon_words,
	// results
	output logic                               chg_flag,
	output logic [23:0]                        chk_sum
);

	logic                             armed_r, armed_nxt;
	logic                             flag_r, flag_nxt;
	logic [EFS_MON_WORDS*16-1:0]      snap_r, snap_nxt;
	logic [23:0]                      sum_r, sum_nxt;
	logic [23:0]                      cur_sum;

	// rotate-xor fold of the monitored words
	function automatic logic [23:0] fold(input logic [EFS_MON_WORDS*16-1:0] w);
		logic [23:0] acc;
		acc = 24'h000000;
		for (int i = 0; i < EFS_MON_WORDS; i++)
		begin
			acc = {acc[20:0], acc[23:21]} ^ {8'h00, w[i*16 +: 16]};
		end
		return acc;
	endfunction

	assign cur_sum = fold(mon_words);

	// next state of the checker
	always_comb
	begin
		armed_nxt = chk_en;
		snap_nxt  = snap_r;
		sum_nxt   = sum_r;
		flag_nxt  = flag_r;
		// RL3 snapshot checksum
		if (chk_en && !armed_r)
		begin
			snap_nxt = mon_words;
			sum_nxt  = cur_sum;
		end
		// RL4 clear on disable
		if (!chk_en)
			flag_nxt = 1'b0;
		// RL1 detect changed bit
		else if (armed_r && (mon_words != snap_r || cur_sum != sum_r))
			flag_nxt = 1'b1;
	end

	// checker registers
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			armed_r <= 1'b0;
			flag_r  <= 1'b0;
			snap_r  <= '0;
			sum_r   <= EFS_RST_CHKSUM;
		end
		else
		begin
			armed_r <= armed_nxt;
			flag_r  <= flag_nxt;
			snap_r  <= snap_nxt;
			sum_r   <= sum_nxt;
		end
	end

	assign chg_flag = flag_r;
	assign chk_sum  = sum_r;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	chk_flag_set_change: assert property ( // RL1
		chk_en && armed_r && mon_words != snap_r |=> chg_flag)
		else $error("register change not flagged");
	chk_flag_clear_only: assert property ( // RL4
		chg_flag && chk_en |=> chg_flag)
		else $error("change flag dropped while check enabled");

endmodule

// ==== rtl/efs_top.sv ====
`timescale 1ns/1ns
// fault flags, fault pin and status append for the converter digital side
module efs_top
	import efs_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [23:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [23:0] reg_rdata,
	// converter side
	input  wire logic        conv_range_fault,
	input  wire logic        crc_mismatch,
	input  wire logic        conv_done,
	input  wire efs_conv_t   conv_in,
	// result stream
	output efs_result_t      res_out,
	output logic             res_valid,
	// sync/fault pin
	input  wire logic        fault_pin_i,
	output logic             fault_pin_o,
	output logic             fault_pin_oe,
	// interrupt
	output logic             irq
);

	// software registers
	logic [15:0]                 ifmode_r, ifmode_nxt;
	logic [15:0]                 pincfg_r, pincfg_nxt;
	logic [15:0]                 cfg_r   [EFS_CFG_COUNT];
	logic [15:0]                 cfg_nxt [EFS_CFG_COUNT];
	logic [3:0]                  irq_st_r, irq_st_nxt;
	logic [3:0]                  irq_mask_r, irq_mask_nxt;
	logic [23:0]                 rdata_r, rdata_nxt;
	// status state
	logic                        crc_flag_r, crc_flag_nxt;
	logic                        rdy_n_r, rdy_n_nxt;
	logic [1:0]                  chan_r, chan_nxt;
	logic [23:0]                 data_r, data_nxt;
	logic                        conv_flag_d_r;
	// result stream
	efs_result_t                 res_r, res_nxt;
	logic                        res_valid_r, res_valid_nxt;
	// pin state
	logic [2:0]                  pin_sync_r;
	logic                        pin_filt_r, pin_filt_nxt;
	logic                        pin_o_r, pin_o_nxt;
	logic                        pin_oe_r, pin_oe_nxt;
	// derived
	logic                        chk_en;
	logic                        reg_flag;
	logic [23:0]                 chk_sum;
	logic [EFS_MON_WORDS*16-1:0] mon_words;
	logic                        pin_role;
	efs_pinfn_t                  pin_fn;
	logic                        in_mode;
	logic                        conv_flag;
	logic                        fault_any;
	logic                        rd_status;
	logic                        rd_data;
	logic [3:0]                  ev;
	logic [7:0]                  status_now;

	assign chk_en    = ifmode_r[EFS_IF_CHECK_EN];
	assign rd_status = reg_rd && reg_addr == EFS_OFS_STATUS;
	assign rd_data   = reg_rd && reg_addr == EFS_OFS_DATA;

	// RL5 monitored set excludes data, status, interface mode
	assign mon_words[15:0] = pincfg_r;
	genvar gi;
	generate
		for (gi = 0; gi < EFS_CFG_COUNT; gi++)
		begin : g_mon
			assign mon_words[(gi+1)*16 +: 16] = cfg_r[gi];
		end
	endgenerate

	// integrity checker
	efs_regchk u_regchk (
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.chk_en    (chk_en),
		.mon_words (mon_words),
		.chg_flag  (reg_flag),
		.chk_sum   (chk_sum)
	);

	// RL6 pin role gate
	assign pin_role = pincfg_r[EFS_PC_SYNC_EN] && !ifmode_r[EFS_IF_ALT_START];
	assign pin_fn   = efs_pinfn_t'(pincfg_r[EFS_PC_FN_LO +: 2]);
	assign in_mode  = pin_role && pin_fn == EFS_FN_IN;

	// RL9 RL16 conversion fault follows range and external pin
	assign conv_flag = conv_range_fault || (in_mode && !pin_filt_r);
	assign fault_any = conv_flag || crc_flag_r || reg_flag;

	// RL17 status byte; RL10 pin level in input mode
	assign status_now = {rdy_n_r, conv_flag, crc_flag_r, reg_flag,
	                     1'b0, in_mode && pin_filt_r, chan_r};

	// interrupt events: conversion fault rise, crc, reg change, done
	assign ev  = {conv_done, reg_flag, crc_mismatch, conv_flag && !conv_flag_d_r};
	assign irq = |(irq_st_r & irq_mask_r);

	// register file and flag next state
	always_comb
	begin
		ifmode_nxt   = ifmode_r;
		pincfg_nxt   = pincfg_r;
		irq_mask_nxt = irq_mask_r;
		for (int i = 0; i < EFS_CFG_COUNT; i++)
			cfg_nxt[i] = cfg_r[i];
		irq_st_nxt   = irq_st_r;
		crc_flag_nxt = crc_flag_r;
		rdy_n_nxt    = rdy_n_r;
		chan_nxt     = chan_r;
		data_nxt     = data_r;
		rdata_nxt    = 24'h000000;
		if (reg_wr)
		begin
			case (reg_addr)
				EFS_OFS_IFMODE:   ifmode_nxt = reg_wdata[15:0];
				EFS_OFS_PINCFG:   pincfg_nxt = reg_wdata[15:0];
				EFS_OFS_IRQ_MASK: irq_mask_nxt = reg_wdata[3:0];
				EFS_OFS_IRQ_ST:   irq_st_nxt = irq_st_r & ~reg_wdata[3:0];
				default:
				begin
					for (int i = 0; i < EFS_CFG_COUNT; i++)
						if (reg_addr == EFS_OFS_CFG0 + 8'(i))
							cfg_nxt[i] = reg_wdata[15:0];
				end
			endcase
		end
		// sticky events win over the write-one clear
		irq_st_nxt = irq_st_nxt | ev;
		// RL15 explicit status read clears, new mismatch wins
		if (rd_status)
			crc_flag_nxt = 1'b0;
		if (crc_mismatch)
			crc_flag_nxt = 1'b1;
		// data register read marks result consumed
		if (rd_data)
			rdy_n_nxt = 1'b1;
		if (conv_done)
		begin
			rdy_n_nxt = 1'b0;
			chan_nxt  = conv_in.chan;
			data_nxt  = conv_in.data;
		end
		if (reg_rd)
		begin
			case (reg_addr)
				EFS_OFS_STATUS:   rdata_nxt = {16'h0000, status_now};
				EFS_OFS_IFMODE:   rdata_nxt = {8'h00, ifmode_r};
				EFS_OFS_REGCHECK: rdata_nxt = chk_sum;
				EFS_OFS_DATA:     rdata_nxt = data_r;
				EFS_OFS_PINCFG:   rdata_nxt = {8'h00, pincfg_r};
				EFS_OFS_IRQ_ST:   rdata_nxt = {20'h00000, irq_st_r};
				EFS_OFS_IRQ_MASK: rdata_nxt = {20'h00000, irq_mask_r};
				default:
				begin
					for (int i = 0; i < EFS_CFG_COUNT; i++)
						if (reg_addr == EFS_OFS_CFG0 + 8'(i))
							rdata_nxt = {8'h00, cfg_r[i]};
				end
			endcase
		end
	end

	// register file flip-flops
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ifmode_r      <= EFS_RST_IFMODE;
			pincfg_r      <= EFS_RST_PINCFG;
			cfg_r[0]      <= EFS_RST_CFG0;
			for (int i = 1; i < EFS_CFG_COUNT; i++)
				cfg_r[i] <= EFS_RST_CFGN;
			irq_st_r      <= 4'h0;
			irq_mask_r    <= 4'h0;
			crc_flag_r    <= 1'b0;
			rdy_n_r       <= 1'b1;
			chan_r        <= 2'h0;
			data_r        <= 24'h000000;
			rdata_r       <= 24'h000000;
			conv_flag_d_r <= 1'b0;
		end
		else
		begin
			ifmode_r      <= ifmode_nxt;
			pincfg_r      <= pincfg_nxt;
			for (int i = 0; i < EFS_CFG_COUNT; i++)
				cfg_r[i] <= cfg_nxt[i];
			irq_st_r      <= irq_st_nxt;
			irq_mask_r    <= irq_mask_nxt;
			crc_flag_r    <= crc_flag_nxt;
			rdy_n_r       <= rdy_n_nxt;
			chan_r        <= chan_nxt;
			data_r        <= data_nxt;
			rdata_r       <= rdata_nxt;
			conv_flag_d_r <= conv_flag;
		end
	end

	assign reg_rdata = rdata_r;

	// result stream next state
	always_comb
	begin
		res_valid_nxt = conv_done;
		res_nxt       = res_r;
		if (conv_done)
		begin
			res_nxt.data = conv_in.data;
			// RL12 append live status; RL13 channel in low bits
			res_nxt.with_stat = ifmode_r[EFS_IF_APPEND];
			res_nxt.stat = ifmode_r[EFS_IF_APPEND] ?
			               {1'b0, status_now[6:2], conv_in.chan} : 8'h00;
		end
	end

	// result stream flip-flops
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			res_r       <= '0;
			res_valid_r <= 1'b0;
		end
		else
		begin
			res_r       <= res_nxt;
			res_valid_r <= res_valid_nxt;
		end
	end

	assign res_out   = res_r;
	assign res_valid = res_valid_r;

	// pin filter and drive next state
	always_comb
	begin
		pin_filt_nxt = (pin_sync_r[1] == pin_sync_r[2]) ? pin_sync_r[2] : pin_filt_r;
		pin_o_nxt    = 1'b0;
		pin_oe_nxt   = 1'b0;
		if (pin_role)
		begin
			case (pin_fn)
				// RL7 open drain, low on any fault
				EFS_FN_OD:
					pin_oe_nxt = fault_any;
				// RL14 general output level
				EFS_FN_GPOUT:
				begin
					pin_oe_nxt = 1'b1;
					pin_o_nxt  = pincfg_r[EFS_PC_PIN_LEVEL];
				end
				// RL11 disabled or input: released
				default:
					pin_oe_nxt = 1'b0;
			endcase
		end
	end

	// pin flip-flops
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pin_sync_r <= 3'h7;
			pin_filt_r <= 1'b1;
			pin_o_r    <= 1'b0;
			pin_oe_r   <= 1'b0;
		end
		else
		begin
			pin_sync_r <= {pin_sync_r[1:0], fault_pin_i};
			pin_filt_r <= pin_filt_nxt;
			pin_o_r    <= pin_o_nxt;
			pin_oe_r   <= pin_oe_nxt;
		end
	end

	assign fault_pin_o  = pin_o_r;
	assign fault_pin_oe = pin_oe_r;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	sequence seq_done_append;
		conv_done && ifmode_r[EFS_IF_APPEND];
	endsequence
	sequence seq_res_with_chan;
		res_valid && res_out.with_stat && res_out.stat[1:0] == $past(conv_in.chan);
	endsequence

	chk_append_status: assert property ( // RL12
		seq_done_append |=> seq_res_with_chan)
		else $error("status not appended to result");
	chk_append_chan: assert property ( // RL13
		conv_done |=> chan_r == $past(conv_in.chan) && (!res_out.with_stat || res_out.stat[1:0] == chan_r))
		else $error("appended channel mismatch");
	chk_reg_clear: assert property ( // RL4
		!chk_en |=> !reg_flag)
		else $error("register flag not cleared by disable");
	chk_crc_set: assert property ( // RL15
		crc_mismatch |=> crc_flag_r ##0 status_now[5])
		else $error("checksum fault not set");
	chk_crc_clear: assert property ( // RL15
		rd_status && !crc_mismatch |=> !crc_flag_r)
		else $error("checksum fault not cleared by status read");
	chk_od_drive: assert property ( // RL7
		pin_role && pin_fn == EFS_FN_OD && fault_any |=> fault_pin_oe && !fault_pin_o)
		else $error("open drain fault not driven low");
	chk_gpo_level: assert property ( // RL14
		pin_role && pin_fn == EFS_FN_GPOUT |=> fault_pin_oe && fault_pin_o == $past(pincfg_r[EFS_PC_PIN_LEVEL]))
		else $error("general output level wrong");
	chk_pin_released: assert property ( // RL6
		!pin_role || pin_fn == EFS_FN_OFF || pin_fn == EFS_FN_IN |=> !fault_pin_oe)
		else $error("pin driven outside its role");
	chk_input_fault: assert property ( // RL9
		in_mode && pin_sync_r[2:1] == 2'b00 |=> !in_mode || status_now[6])
		else $error("external fault not in conversion flag");
	chk_pin_level: assert property ( // RL10
		in_mode && pin_sync_r[2] == pin_sync_r[1] |=> !in_mode || status_now[2] == $past(pin_sync_r[2]))
		else $error("pin level not mirrored in status");
	chk_conv_follow: assert property ( // RL16
		!conv_range_fault && !in_mode |-> !status_now[6])
		else $error("conversion fault held after range cleared");

endmodule

// ==== verification/efs_pin_partner.sv ====
`timescale 1ns/1ns
// other component on the shared fault line, plus the pin's pull-up
module efs_pin_partner
(
	// device pin drivers
	input  wire logic fault_pin_o,
	input  wire logic fault_pin_oe,
	// other component pulls low while it has a fault
	input  wire logic ext_fault,
	// resolved wire level
	output logic      pin_level
);
	// a low driver wins, the pull-up holds the line high otherwise
	assign pin_level = ext_fault ? 1'b0 : (fault_pin_oe ? fault_pin_o : 1'b1);
endmodule

// ==== verification/tb_error_flag_and_status_append.sv ====
`timescale 1ns/1ns
`define CHK(g, e) \
	begin \
		samples_checked++; \
		if ((g) !== (e)) \
		begin \
			err_count++; \
			$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); \
		end \
	end
// self-checking bench for fault flags, fault pin and status append
module tb_error_flag_and_status_append import efs_pkg::*;;
	logic        sys_clk;
	logic        rstn;
	logic [7:0]  reg_addr;
	logic [23:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [23:0] reg_rdata;
	logic        conv_range_fault;
	logic        crc_mismatch;
	logic        conv_done;
	efs_conv_t   conv_in;
	efs_result_t res_out;
	logic        res_valid;
	logic        fault_pin_o;
	logic        fault_pin_oe;
	logic        pin_level;
	logic        ext_fault;
	logic        irq;
	int          err_count;
	int          samples_checked;
	logic [23:0] rv;

	efs_top dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_range_fault(conv_range_fault),
		.crc_mismatch(crc_mismatch), .conv_done(conv_done), .conv_in(conv_in), .res_out(res_out),
		.res_valid(res_valid), .fault_pin_i(pin_level), .fault_pin_o(fault_pin_o),
		.fault_pin_oe(fault_pin_oe), .irq(irq));
	efs_pin_partner peer (.fault_pin_o(fault_pin_o), .fault_pin_oe(fault_pin_oe),
		.ext_fault(ext_fault), .pin_level(pin_level));

	// 125 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// one-cycle register write
	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// one-cycle read, data taken in the following cycle
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		rv = reg_rdata;
	endtask
	task automatic pulse_crc;
		@(posedge sys_clk);
		crc_mismatch <= 1'b1;
		@(posedge sys_clk);
		crc_mismatch <= 1'b0;
		tick(2);
	endtask
	task automatic set_range(input logic v);
		@(posedge sys_clk);
		conv_range_fault <= v;
		tick(2);
	endtask
	// one conversion, result judged in the next cycle
	task automatic conv(input logic [23:0] d, input logic [1:0] ch, input logic [7:0] st, input logic ws);
		@(posedge sys_clk);
		conv_done <= 1'b1;
		conv_in   <= '{data: d, chan: ch};
		@(posedge sys_clk);
		conv_done <= 1'b0;
		#1;
		`CHK(res_valid, 1'b1)
		`CHK(res_out, {d, st, ws})
	endtask

	task automatic t_reset;
		rd(EFS_OFS_IFMODE);
		`CHK(rv, {8'h00, EFS_RST_IFMODE})
		rd(EFS_OFS_PINCFG);
		`CHK(rv, {8'h00, EFS_RST_PINCFG})
		rd(EFS_OFS_STATUS);
		`CHK(rv, 24'h000080)
		rd(8'h7f);
		`CHK(rv, 24'h000000)
	endtask
	task automatic t_flags;
		pulse_crc();
		rd(EFS_OFS_STATUS);
		`CHK(rv[5], 1'b1)
		rd(EFS_OFS_STATUS);
		`CHK(rv[5], 1'b0)
		set_range(1'b1);
		rd(EFS_OFS_DATA);
		rd(EFS_OFS_STATUS);
		`CHK(rv[6], 1'b1)
		set_range(1'b0);
		rd(EFS_OFS_STATUS);
		`CHK(rv[6], 1'b0)
	endtask
	task automatic t_regchk;
		logic [23:0] s;
		wr(EFS_OFS_IFMODE, 24'h000020);
		tick(3);
		rd(EFS_OFS_REGCHECK);
		s = rv;
		// rotate-left-3 xor fold of pincfg and cfg words at their reset values
		`CHK(s, 24'h800248)
		wr(EFS_OFS_REGCHECK, ~s);
		rd(EFS_OFS_REGCHECK);
		`CHK(rv, s)
		wr(EFS_OFS_IFMODE, 24'h000060);
		tick(2);
		rd(EFS_OFS_STATUS);
		`CHK(rv[4], 1'b0)
		wr(EFS_OFS_CFG0 + 8'h01, 24'h000002);
		tick(2);
		rd(EFS_OFS_STATUS);
		`CHK(rv[4], 1'b1)
		rd(EFS_OFS_STATUS);
		`CHK(rv[4], 1'b1)
		wr(EFS_OFS_IFMODE, 24'h000000);
		tick(2);
		rd(EFS_OFS_STATUS);
		`CHK(rv[4], 1'b0)
		wr(EFS_OFS_CFG0 + 8'h02, 24'h000003);
		wr(EFS_OFS_IFMODE, 24'h000020);
		tick(2);
		rd(EFS_OFS_STATUS);
		`CHK(rv[4], 1'b0)
		wr(EFS_OFS_IFMODE, 24'h000000);
		tick(2);
	endtask
	task automatic t_pin;
		wr(EFS_OFS_PINCFG, 24'h000c00);
		tick(2);
		`CHK(pin_level, 1'b1)
		set_range(1'b1);
		`CHK(pin_level, 1'b0)
		wr(EFS_OFS_IFMODE, 24'h001000);
		tick(2);
		`CHK(fault_pin_oe, 1'b0)
		wr(EFS_OFS_IFMODE, 24'h000000);
		set_range(1'b0);
		`CHK(pin_level, 1'b1)
		pulse_crc();
		`CHK(pin_level, 1'b0)
		rd(EFS_OFS_STATUS);
		`CHK(rv[5], 1'b1)
		tick(2);
		`CHK(pin_level, 1'b1)
		wr(EFS_OFS_PINCFG, 24'h000a00);
		tick(8);
		`CHK(fault_pin_oe, 1'b0)
		rd(EFS_OFS_STATUS);
		`CHK(rv[2], 1'b1)
		@(posedge sys_clk);
		ext_fault <= 1'b1;
		tick(8);
		rd(EFS_OFS_STATUS);
		`CHK(rv[6:2], 5'b10000)
		@(posedge sys_clk);
		ext_fault <= 1'b0;
		tick(8);
		rd(EFS_OFS_STATUS);
		`CHK(rv[6], 1'b0)
		wr(EFS_OFS_PINCFG, 24'h000f00);
		tick(2);
		`CHK({fault_pin_oe, fault_pin_o}, 2'b11)
		wr(EFS_OFS_PINCFG, 24'h000e00);
		tick(2);
		`CHK({fault_pin_oe, fault_pin_o}, 2'b10)
		wr(EFS_OFS_PINCFG, 24'h000600);
		tick(2);
		`CHK(fault_pin_oe, 1'b0)
		wr(EFS_OFS_PINCFG, 24'h000800);
		tick(2);
		`CHK(fault_pin_oe, 1'b0)
	endtask
	task automatic t_append;
		logic [1:0] c;
		wr(EFS_OFS_IFMODE, 24'h000040);
		for (int i = 0; i < 4; i++)
		begin
			c = i[1:0];
			conv(24'habc000 | 24'(i), c, {6'h00, c}, 1'b1);
		end
		set_range(1'b1);
		conv(24'h7fffff, 2'd1, 8'h41, 1'b1);
		set_range(1'b0);
		wr(EFS_OFS_IFMODE, 24'h000000);
		conv(24'h123456, 2'd3, 8'h00, 1'b0);
		rd(EFS_OFS_STATUS);
		`CHK(rv[1:0], 2'd3)
	endtask
	task automatic t_irq;
		wr(EFS_OFS_IRQ_ST, 24'h00000f);
		wr(EFS_OFS_IRQ_MASK, 24'h000008);
		tick(2);
		`CHK(irq, 1'b0)
		conv(24'h000111, 2'd0, 8'h00, 1'b0);
		tick(2);
		`CHK(irq, 1'b1)
		wr(EFS_OFS_IRQ_MASK, 24'h000000);
		tick(2);
		`CHK(irq, 1'b0)
		wr(EFS_OFS_IRQ_MASK, 24'h000008);
		tick(2);
		`CHK(irq, 1'b1)
		wr(EFS_OFS_IRQ_ST, 24'h000008);
		tick(2);
		`CHK(irq, 1'b0)
	endtask

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// main sequence
	initial
	begin
		err_count = 0;
		samples_checked = 0;
		rstn = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 24'h000000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		conv_range_fault = 1'b0;
		crc_mismatch = 1'b0;
		conv_done = 1'b0;
		conv_in = '0;
		ext_fault = 1'b0;
		repeat (5) @(posedge sys_clk);
		rstn <= 1'b1;
		t_reset();
		t_flags();
		t_regchk();
		t_pin();
		t_append();
		t_irq();
		tally_and_finish();
	end

	// watchdog against a hang
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		err_count++;
		tally_and_finish();
	end
endmodule
